// ==== common/mpl_pkg.sv ====
package mpl_pkg;

  // Byte address width of the register window.
  localparam int ADDR_W = 8;

  // Register byte offsets, one aligned word each.
  localparam logic [7:0] OFS_BIT_LAT = 8'h00;
  localparam logic [7:0] OFS_BIT_CMOS = 8'h04;
  localparam logic [7:0] OFS_BIT_IN = 8'h08;
  localparam logic [7:0] OFS_NIB_LAT = 8'h0c;
  localparam logic [7:0] OFS_NIB_CMOS = 8'h10;
  localparam logic [7:0] OFS_NIB_IN = 8'h14;
  localparam logic [7:0] OFS_PULL = 8'h18;
  localparam logic [7:0] OFS_KEY = 8'h1c;
  localparam logic [7:0] OFS_FUNC = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;
  localparam logic [7:0] OFS_SKIP = 8'h28;

  // Reset values: latches high, open-drain, no pull-up, no wakeup.
  localparam logic [9:0] BIT_LAT_RST = 10'h3ff;
  localparam logic [7:0] BIT_CMOS_RST = 8'h00;
  localparam logic [19:0] NIB_LAT_RST = 20'hfffff;
  localparam logic [11:0] NIB_CMOS_RST = 12'h000;
  localparam logic [7:0] PULL_RST = 8'h00;
  localparam logic [9:0] KEY_RST = 10'h000;
  localparam logic [2:0] SKIP_RST = 3'h0;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Role of the first timer pin.
  typedef enum logic [1:0] {
    TA_PORT = 2'h0,
    TA_EXT = 2'h1,
    TA_OUT1 = 2'h2,
    TA_OUT2 = 2'h3
  } mpl_tmra_t;

  // Role of the second timer pin.
  typedef enum logic [1:0] {
    TB_PORT = 2'h0,
    TB_EXT = 2'h1,
    TB_PWM = 2'h2,
    TB_RSVD = 2'h3
  } mpl_tmrb_t;

  // LCD duty selection.
  typedef enum logic [1:0] {
    DUTY_OFF = 2'h0,
    DUTY_HALF = 2'h1,
    DUTY_THIRD = 2'h2,
    DUTY_QUARTER = 2'h3
  } mpl_duty_t;

  // Function register layout, bit 0 first from the right.
  typedef struct packed {
    logic port_c_lat;
    logic [2:0] bias_sel;
    mpl_duty_t duty;
    mpl_tmrb_t tmrb;
    mpl_tmra_t tmra;
    logic sclk_int;
    logic serial_en;
  } mpl_func_t;

  localparam mpl_func_t FUNC_RST = '{
    port_c_lat: 1'b1,
    bias_sel: 3'h0,
    duty: DUTY_OFF,
    tmrb: TB_PORT,
    tmra: TA_PORT,
    sclk_int: 1'b0,
    serial_en: 1'b0
  };

endpackage

// ==== rtl/mpl_sync.sv ====
`timescale 1ns/10ps
// Three-stage pin synchroniser; a bit changes once stages two and
// three agree, which also rejects a single-cycle glitch.
module mpl_sync
  import mpl_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  // All stages of the chain.
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] q;
  } mpl_sync_st_t;

  mpl_sync_st_t s_q;
  mpl_sync_st_t s_d;

  // Stage one feeds only stage two; the output follows on agreement.
  always_comb
  begin
    s_d = s_q;
    s_d.f1 = pin_i;
    s_d.f2 = s_q.f1;
    s_d.f3 = s_q.f2;
    s_d.q = (~(s_q.f2 ^ s_q.f3) & s_q.f3) | ((s_q.f2 ^ s_q.f3) & s_q.q);
  end

  // Synchronous reset to the idle pin level.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= {4{RST}};
    else
      s_q <= s_d;
  end

  assign level_o = s_q.q;

endmodule

// ==== rtl/mpl_pad.sv ====
`timescale 1ns/10ps
// Registered pad drivers: push-pull drives the latch value, open-drain
// only pulls low and releases the pin for a one.
module mpl_pad
  import mpl_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] lat_i,
  input wire logic [W-1:0] cmos_i,
  output logic [W-1:0] pad_o,
  output logic [W-1:0] pad_oe
);

  // Registered pad state.
  typedef struct packed {
    logic [W-1:0] o;
    logic [W-1:0] oe;
  } mpl_pad_st_t;

  mpl_pad_st_t s_q;
  mpl_pad_st_t s_d;

  // Open-drain with latch one leaves the pin free for input use.
  always_comb
  begin
    s_d.o = lat_i & cmos_i;
    s_d.oe = cmos_i | ~lat_i;
  end

  // Pins float during reset.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pad_o = s_q.o;
  assign pad_oe = s_q.oe;

endmodule

// ==== rtl/mpl_top.sv ====
`timescale 1ns/10ps
module mpl_top
  import mpl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] bit_port_io_i,
  output logic [7:0] bit_port_io_o,
  output logic [7:0] bit_port_io_oe,
  input wire logic [1:0] bit_port_out_i,
  output logic [1:0] bit_port_out_o,
  output logic [1:0] bit_port_out_oe,
  input wire logic [19:0] nibble_port_i,
  output logic [19:0] nibble_port_o,
  output logic [19:0] nibble_port_oe,
  output logic [7:0] nibble_pullup_en,
  input wire logic timer_io_pin_b_i,
  output logic timer_io_pin_b_o,
  output logic timer_io_pin_b_oe,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  input wire logic brownout_enable_pin,
  input wire logic wdt_reset,
  input wire logic por_reset,
  input wire logic brownout_reset,
  output logic sys_reset_req,
  output logic brownout_run,
  input wire logic serial_tx_data,
  input wire logic serial_clk_out,
  output logic serial_rx_data,
  output logic serial_clk_in,
  input wire logic timer1_underflow,
  input wire logic timer2_underflow,
  input wire logic timer4_pwm,
  output logic timer1_ext_clk,
  output logic timer3_ext_clk,
  output logic ext_irq_a_level,
  output logic ext_irq_b_level,
  output logic [7:0] analog_in_pins,
  output logic key_wake_req,
  output logic skip_cond,
  input wire logic [3:0] lcd_com_drv,
  input wire logic [19:0] lcd_seg_drv,
  output logic [3:0] lcd_common_pins,
  output logic [19:0] lcd_segment_pins,
  output logic [2:0] lcd_bias_pins
);

  // Whole module state, bus slave and pin control together.
  typedef struct packed {
    logic aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [9:0] bit_lat;
    logic [7:0] bit_cmos;
    logic [19:0] nib_lat;
    logic [11:0] nib_cmos;
    logic [7:0] pull;
    logic [9:0] key;
    mpl_func_t func;
    logic [2:0] skip_idx;
    logic wake_flag;
    logic div2;
    logic tb_o;
    logic tb_oe;
    logic rst_oe;
    logic sys_rst;
    logic bo_run;
    logic rx;
    logic sclk_in;
    logic t1_clk;
    logic t3_clk;
    logic irq_a;
    logic irq_b;
    logic [7:0] ain;
    logic wake;
    logic skip;
    logic [3:0] com;
    logic [19:0] seg;
    logic [2:0] bias;
  } mpl_top_st_t;

  mpl_top_st_t s_q;
  mpl_top_st_t s_d;

  // Synchronised pin levels.
  logic [7:0] bit_in;
  logic [1:0] irq_in;
  logic [19:0] nib_in;
  logic tb_in;
  logic rst_in;
  logic bo_en;
  // Latch values after alternate functions are merged in.
  logic [7:0] bit_eff;

  // Merges a write into a register image under the byte strobes.
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = dat[8*i +: 8];
    return r;
  endfunction

  // True for every byte address that holds a register.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == OFS_BIT_LAT || a == OFS_BIT_CMOS || a == OFS_BIT_IN ||
           a == OFS_NIB_LAT || a == OFS_NIB_CMOS || a == OFS_NIB_IN ||
           a == OFS_PULL || a == OFS_KEY || a == OFS_FUNC ||
           a == OFS_STAT || a == OFS_SKIP;
  endfunction

  // Common commons for each duty; unused commons stay at zero.
  function automatic logic [3:0] duty_mask(input mpl_duty_t d);
    logic [3:0] m;
    unique case (d)
      DUTY_HALF: m = 4'h3;
      DUTY_THIRD: m = 4'h7;
      DUTY_QUARTER: m = 4'hf;
      DUTY_OFF: m = 4'h0;
    endcase
    return m;
  endfunction

  // One synchroniser for every pin that is read back; all idle high.
  mpl_sync #(
    .W(33),
    .RST({33{1'b1}})
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_i({brownout_enable_pin, reset_pin_i, timer_io_pin_b_i,
            nibble_port_i, bit_port_out_i, bit_port_io_i}),
    .level_o({bo_en, rst_in, tb_in, nib_in, irq_in, bit_in})
  );

  // Serial data, serial clock and the halved timer underflow replace
  // the latch only on the pins that carry them.
  always_comb
  begin
    bit_eff = s_q.bit_lat[7:0];
    if (s_q.func.serial_en)
      bit_eff[5] = serial_tx_data;
    if (s_q.func.serial_en && s_q.func.sclk_int)
      bit_eff[6] = serial_clk_out;
    if (s_q.func.tmra == TA_OUT1 || s_q.func.tmra == TA_OUT2)
      bit_eff[7] = s_q.div2;
  end

  // Low port, upper bits and the nibbles share one bank of drivers.
  // The upper bits and nibbles c,d are forced open-drain; nibbles a,b,e
  // and the low port follow software.
  mpl_pad #(
    .W(30)
  ) u_pad (
    .aclk(aclk),
    .aresetn(aresetn),
    .lat_i({s_q.nib_lat, s_q.bit_lat[9:8], bit_eff}),
    .cmos_i({s_q.nib_cmos[11:8], 8'h00, s_q.nib_cmos[7:0], 2'b00,
             s_q.bit_cmos}),
    .pad_o({nibble_port_o, bit_port_out_o, bit_port_io_o}),
    .pad_oe({nibble_port_oe, bit_port_out_oe, bit_port_io_oe})
  );

  // Register file, bus handshakes and all pin-function state.
  always_comb
  begin
    logic [31:0] rd;
    logic [31:0] nw;
    logic wake_now;
    s_d = s_q;
    rd = 32'h0000_0000;
    nw = 32'h0000_0000;
    wake_now = 1'b0;

    // Write address and data are taken independently, in either order.
    if (s_q.awready && s_axi_awvalid)
    begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid)
    begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end

    // Key-on wakeup: an enabled pin held low asks for wakeup.
    wake_now = |(s_q.key[7:0] & ~nib_in[7:0])
             | |(s_q.key[9:8] & ~irq_in);
    s_d.wake = wake_now;

    // Once both halves are held the write is performed and answered.
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid)
    begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(s_q.aw_addr) ? RESP_OKAY : RESP_DECERR;
      unique case (s_q.aw_addr)
        OFS_BIT_LAT:
        begin
          nw = wmerge({22'h0, s_q.bit_lat}, s_q.w_data, s_q.w_strb);
          s_d.bit_lat = nw[9:0];
        end
        OFS_BIT_CMOS:
        begin
          nw = wmerge({24'h0, s_q.bit_cmos}, s_q.w_data, s_q.w_strb);
          s_d.bit_cmos = nw[7:0];
        end
        OFS_NIB_LAT:
        begin
          nw = wmerge({12'h0, s_q.nib_lat}, s_q.w_data, s_q.w_strb);
          s_d.nib_lat = nw[19:0];
        end
        OFS_NIB_CMOS:
        begin
          nw = wmerge({20'h0, s_q.nib_cmos}, s_q.w_data, s_q.w_strb);
          s_d.nib_cmos = nw[11:0];
        end
        OFS_PULL:
        begin
          nw = wmerge({24'h0, s_q.pull}, s_q.w_data, s_q.w_strb);
          s_d.pull = nw[7:0];
        end
        OFS_KEY:
        begin
          nw = wmerge({22'h0, s_q.key}, s_q.w_data, s_q.w_strb);
          s_d.key = nw[9:0];
        end
        OFS_FUNC:
        begin
          nw = wmerge({20'h0, s_q.func}, s_q.w_data, s_q.w_strb);
          s_d.func = mpl_func_t'(nw[11:0]);
        end
        OFS_STAT:
        begin
          // Writing one clears the wakeup flag.
          if (s_q.w_strb[0] && s_q.w_data[0])
            s_d.wake_flag = 1'b0;
        end
        OFS_SKIP:
        begin
          nw = wmerge({29'h0, s_q.skip_idx}, s_q.w_data, s_q.w_strb);
          s_d.skip_idx = nw[2:0];
        end
        default:
        begin
          // Input images and unmapped addresses ignore the data.
          nw = 32'h0000_0000;
        end
      endcase
    end
    // A wakeup in the clearing cycle sets the flag again.
    if (wake_now)
      s_d.wake_flag = 1'b1;
    if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;

    // Reads answer one cycle after the address is taken.
    unique case (s_axi_araddr)
      OFS_BIT_LAT: rd = {22'h0, s_q.bit_lat};
      OFS_BIT_CMOS: rd = {24'h0, s_q.bit_cmos};
      OFS_BIT_IN: rd = {22'h0, irq_in, bit_in};
      OFS_NIB_LAT: rd = {12'h0, s_q.nib_lat};
      OFS_NIB_CMOS: rd = {20'h0, s_q.nib_cmos};
      OFS_NIB_IN: rd = {12'h0, nib_in};
      OFS_PULL: rd = {24'h0, s_q.pull};
      OFS_KEY: rd = {22'h0, s_q.key};
      OFS_FUNC: rd = {20'h0, s_q.func};
      OFS_STAT: rd = {29'h0, s_q.bo_run, s_q.sys_rst, s_q.wake_flag};
      OFS_SKIP: rd = {27'h0, s_q.skip, 1'b0, s_q.skip_idx};
      default: rd = 32'h0000_0000;
    endcase
    if (s_q.arready && s_axi_arvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
    end
    if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;

    // One write and one read in flight; ready falls while held.
    s_d.awready = !s_d.aw_full && !s_d.bvalid;
    s_d.wready = !s_d.w_full && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;

    // Pin level for the skip test; the index picks one low port bit.
    s_d.skip = bit_in[s_q.skip_idx];

    // Halve the selected underflow for the timer pin a output.
    if ((s_q.func.tmra == TA_OUT1 && timer1_underflow) ||
        (s_q.func.tmra == TA_OUT2 && timer2_underflow))
      s_d.div2 = !s_q.div2;
    s_d.t1_clk = (s_q.func.tmra == TA_EXT) && bit_in[7];

    // Port C: push-pull output, PWM ORed in so a latched high stays,
    // released as an input while it counts external events.
    s_d.tb_o = s_q.func.port_c_lat ||
               (s_q.func.tmrb == TB_PWM && timer4_pwm);
    s_d.tb_oe = s_q.func.tmrb != TB_EXT;
    s_d.t3_clk = (s_q.func.tmrb == TB_EXT) && tb_in;

    // Serial receive and external serial clock come from the pins
    // while the port inputs remain visible to software.
    s_d.rx = s_q.func.serial_en && bit_in[4];
    s_d.sclk_in = s_q.func.serial_en && !s_q.func.sclk_int &&
                  bit_in[6];

    // External interrupt levels are the upper pins as read back.
    s_d.irq_a = irq_in[0];
    s_d.irq_b = irq_in[1];

    // Nibbles c and d feed the converter inputs in bit order.
    s_d.ain = nib_in[15:8];

    // Reset pin pulled low for any internal reset source; a low from
    // the board is passed on as a system reset too.
    s_d.rst_oe = wdt_reset || por_reset || brownout_reset;
    s_d.sys_rst = s_d.rst_oe || !rst_in;
    s_d.bo_run = bo_en;

    // LCD commons masked by duty; shared pins take one role at a time.
    s_d.com = lcd_com_drv & duty_mask(s_q.func.duty);
    s_d.seg = lcd_seg_drv & ~{17'h0, s_q.func.bias_sel};
    s_d.bias = {s_q.func.bias_sel[0], s_q.func.bias_sel[1],
                s_q.func.bias_sel[2]};
  end

  // State register; reset leaves every pin safe and released but Port C, push-pull high once reset ends.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.bit_lat <= BIT_LAT_RST;
      s_q.bit_cmos <= BIT_CMOS_RST;
      s_q.nib_lat <= NIB_LAT_RST;
      s_q.nib_cmos <= NIB_CMOS_RST;
      s_q.pull <= PULL_RST;
      s_q.key <= KEY_RST;
      s_q.func <= FUNC_RST;
      s_q.skip_idx <= SKIP_RST;
    end
    else
      s_q <= s_d;
  end

  // Outputs, each straight from a flip-flop except reset_pin_o, which is tied low.
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign nibble_pullup_en = s_q.pull;
  assign timer_io_pin_b_o = s_q.tb_o;
  assign timer_io_pin_b_oe = s_q.tb_oe;
  assign reset_pin_o = 1'b0 & s_q.rst_oe;
  assign reset_pin_oe = s_q.rst_oe;
  assign sys_reset_req = s_q.sys_rst;
  assign brownout_run = s_q.bo_run;
  assign serial_rx_data = s_q.rx;
  assign serial_clk_in = s_q.sclk_in;
  assign timer1_ext_clk = s_q.t1_clk;
  assign timer3_ext_clk = s_q.t3_clk;
  assign ext_irq_a_level = s_q.irq_a;
  assign ext_irq_b_level = s_q.irq_b;
  assign analog_in_pins = s_q.ain;
  assign key_wake_req = s_q.wake;
  assign skip_cond = s_q.skip;
  assign lcd_common_pins = s_q.com;
  assign lcd_segment_pins = s_q.seg;
  assign lcd_bias_pins = s_q.bias;

endmodule

// ==== verif/mpl_top_assertions.sv ====
`timescale 1ns/10ps
// Pin-side checks of the port block, on top-level ports only.
module mpl_chk
  import mpl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wdt_reset,
  input wire logic por_reset,
  input wire logic brownout_reset,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe,
  input wire logic sys_reset_req,
  input wire logic brownout_enable_pin,
  input wire logic brownout_run,
  input wire logic [1:0] bit_port_out_i,
  input wire logic [1:0] bit_port_out_o,
  input wire logic [1:0] bit_port_out_oe,
  input wire logic [19:0] nibble_port_i,
  input wire logic [19:0] nibble_port_o,
  input wire logic [19:0] nibble_port_oe,
  input wire logic [7:0] analog_in_pins,
  input wire logic ext_irq_a_level,
  input wire logic ext_irq_b_level,
  input wire logic [19:0] lcd_segment_pins,
  input wire logic [2:0] lcd_bias_pins
);
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Any internal reset source, all of them levels.
  logic any_src;
  assign any_src = wdt_reset | por_reset | brownout_reset;

  chk_rst_drive:
    assert property (any_src |-> ##[1:3] reset_pin_oe)
    else $error("Reset pin not pulled low.");
  chk_rst_od:
    assert property (reset_pin_oe |-> !reset_pin_o)
    else $error("Reset pin driven high.");
  chk_rst_req:
    assert property (any_src |-> ##[1:3] sys_reset_req)
    else $error("Reset request missing.");
  chk_bo_on:
    assert property (brownout_enable_pin [*8] |-> brownout_run)
    else $error("Detector idle while enabled.");
  chk_bo_off:
    assert property (!brownout_enable_pin [*8] |-> !brownout_run)
    else $error("Detector runs while disabled.");
  chk_up_od:
    assert property ((bit_port_out_oe & bit_port_out_o) == 2'h0)
    else $error("Upper bit driven high.");
  chk_nib_od:
    assert property ((nibble_port_oe[15:8] & nibble_port_o[15:8]) == 8'h00)
    else $error("Analog nibble driven high.");
  chk_ain_lvl:
    assert property ($stable(nibble_port_i[15:8]) [*8]
      |-> analog_in_pins == nibble_port_i[15:8])
    else $error("Analog input image wrong.");
  chk_irq_lvl:
    assert property ($stable(bit_port_out_i) [*8]
      |-> {ext_irq_b_level, ext_irq_a_level} == bit_port_out_i)
    else $error("Interrupt level wrong.");
  chk_bias_seg:
    assert property ((lcd_bias_pins & {lcd_segment_pins[0],
      lcd_segment_pins[1], lcd_segment_pins[2]}) == 3'h0)
    else $error("Pin used as bias and segment.");
endmodule

bind mpl_top mpl_chk u_chk (
  .aclk, .aresetn, .wdt_reset, .por_reset, .brownout_reset,
  .reset_pin_o, .reset_pin_oe, .sys_reset_req, .brownout_enable_pin,
  .brownout_run, .bit_port_out_i, .bit_port_out_o, .bit_port_out_oe,
  .nibble_port_i, .nibble_port_o, .nibble_port_oe, .analog_in_pins,
  .ext_irq_a_level, .ext_irq_b_level, .lcd_segment_pins, .lcd_bias_pins
);

// ==== verif/mpl_board.sv ====
`timescale 1ns/10ps
// Board around the pins: a pull-up on every line and keys that short
// a line to ground. A low always wins, so a push-pull high against a
// pressed key reads low, as it would on real copper.
module mpl_board
#(
  parameter int W = 8
)
(
  input wire logic [W-1:0] drv_o,
  input wire logic [W-1:0] drv_oe,
  input wire logic [W-1:0] key_low,
  output logic [W-1:0] pin
);
  // Released lines rise to the pull-up level.
  assign pin = ~key_low & ~(drv_oe & ~drv_o);
endmodule

// ==== verif/mcu_port_pin_logic_tb.sv ====
`timescale 1ns/10ps
// Bench: AXI4-Lite register traffic plus key presses on the board.
module mcu_port_pin_logic_tb
  import mpl_pkg::*;
();
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  // Pressed keys, one per board line; pin is what the lines show.
  logic [31:0] key = 32'h0;
  logic [31:0] pin;
  logic [7:0] io_o, io_oe, pull_en, ain;
  logic [1:0] up_o, up_oe;
  logic [19:0] nb_o, nb_oe, seg;
  logic [2:0] bias;
  logic [2:0] src = 3'h0;
  logic bo_en = 1'h1, pwm = 1'h0, uf1 = 1'h0, lv;
  logic pb_o, pb_oe, rs_o, rs_oe, sreq, bo_run, t1c, t3c;
  logic irq_a, irq_b, wake, skip;
  logic stx = 1'h0, srx, sck_in;
  logic [3:0] com_drv = 4'hf, com;
  int err_total = 0;
  int samples_checked = 0;

  always #2 aclk = ~aclk;

  mpl_board #(.W(32)) u_board (
    .drv_o({rs_o, pb_o, nb_o, up_o, io_o}),
    .drv_oe({rs_oe, pb_oe, nb_oe, up_oe, io_oe}),
    .key_low(key), .pin(pin)
  );

  mpl_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bit_port_io_i(pin[7:0]), .bit_port_io_o(io_o), .bit_port_io_oe(io_oe),
    .bit_port_out_i(pin[9:8]), .bit_port_out_o(up_o),
    .bit_port_out_oe(up_oe), .nibble_port_i(pin[29:10]),
    .nibble_port_o(nb_o), .nibble_port_oe(nb_oe),
    .nibble_pullup_en(pull_en), .timer_io_pin_b_i(pin[30]),
    .timer_io_pin_b_o(pb_o), .timer_io_pin_b_oe(pb_oe),
    .reset_pin_i(pin[31]), .reset_pin_o(rs_o), .reset_pin_oe(rs_oe),
    .brownout_enable_pin(bo_en), .wdt_reset(src[0]), .por_reset(src[1]),
    .brownout_reset(src[2]), .sys_reset_req(sreq), .brownout_run(bo_run),
    .serial_tx_data(stx), .serial_clk_out(1'h0), .serial_rx_data(srx),
    .serial_clk_in(sck_in), .timer1_underflow(uf1),
    .timer2_underflow(1'h0),
    .timer4_pwm(pwm), .timer1_ext_clk(t1c), .timer3_ext_clk(t3c),
    .ext_irq_a_level(irq_a), .ext_irq_b_level(irq_b),
    .analog_in_pins(ain), .key_wake_req(wake), .skip_cond(skip),
    .lcd_com_drv(com_drv), .lcd_seg_drv(20'hfffff), .lcd_common_pins(com),
    .lcd_segment_pins(seg), .lcd_bias_pins(bias)
  );

  // Bus write; address and data are each dropped once taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      awvalid <= awvalid & !awready;
      wvalid <= wvalid & !wready;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask

  // Bus read; data and response are taken at the rvalid edge.
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      arvalid <= arvalid & !arready;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  // Compare and count; four-state equality so an unknown matches only an unknown.
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk({r, d}, {RESP_OKAY, e});
  endtask

  task automatic wc(input logic [7:0] a, input logic [31:0] v);
    axw(a, v);
    chk(r, RESP_OKAY);
  endtask

  // Pin inputs pass a synchroniser, so give them a few cycles.
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic final_report;
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // The run needs a few hundred cycles; this cuts a hang.
  initial
  begin
    #40000;
    err_total++;
    final_report;
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rc(OFS_BIT_LAT, 32'h3ff);
    rc(OFS_BIT_CMOS, 32'h0);
    rc(OFS_NIB_LAT, 32'hfffff);
    rc(OFS_NIB_CMOS, 32'h0);
    rc(OFS_PULL, 32'h0);
    rc(OFS_KEY, 32'h0);
    chk({io_oe, up_oe, nb_oe, pull_en}, 38'h0);
    // Unmapped place refused; pin image ignores writes.
    axw(8'h40, 32'h0);
    chk(r, RESP_DECERR);
    axr(8'h40);
    chk({r, d}, {RESP_DECERR, 32'h0});
    wc(OFS_BIT_IN, 32'h0);
    rc(OFS_BIT_IN, 32'h3ff);
    // Mixed drivers on the low port, two keys pressed.
    key <= 32'h18;
    wc(OFS_BIT_CMOS, 32'h05);
    wc(OFS_BIT_LAT, 32'h3fc);
    wt(8);
    chk({io_oe, io_o & io_oe}, 16'h0704);
    rc(OFS_BIT_IN, 32'h3e4);
    wc(OFS_SKIP, 32'h3);
    wt(8);
    chk(skip, 1'h0);
    rc(OFS_SKIP, 32'h3);
    wc(OFS_SKIP, 32'h2);
    wt(8);
    chk(skip, 1'h1);
    rc(OFS_SKIP, 32'h12);
    // Upper bit low while still read as interrupt level.
    wc(OFS_BIT_LAT, 32'h2fc);
    wt(8);
    chk({up_oe, up_o & up_oe, irq_b, irq_a}, 6'h12);
    // Nibble ports: drivers, analog image, pull-ups, wakeup.
    key <= 32'h400000;
    wc(OFS_NIB_CMOS, 32'hf0f);
    wc(OFS_NIB_LAT, 32'h0f0f0);
    wt(8);
    chk({nb_oe, nb_o & nb_oe, ain}, {20'hf0f0f, 20'h0, 8'he0});
    wc(OFS_PULL, 32'h5a);
    wt(2);
    chk(pull_en, 8'h5a);
    wc(OFS_KEY, 32'h10);
    wt(8);
    chk(wake, 1'h0);
    key <= 32'h404000;
    wt(8);
    chk(wake, 1'h1);
    wc(OFS_KEY, 32'h0);
    wt(8);
    chk(wake, 1'h0);
    wc(OFS_KEY, 32'h100);
    wt(8);
    chk(wake, 1'h1);
    // A clear while the key is still held loses to the set.
    wc(OFS_STAT, 32'h1);
    rc(OFS_STAT, 32'h5);
    wc(OFS_KEY, 32'h0);
    wc(OFS_STAT, 32'h1);
    rc(OFS_STAT, 32'h4);
    // Timer pins: outputs first, then external clock inputs.
    key <= 32'h0;
    wc(OFS_FUNC, 32'h28);
    pwm <= 1'h1;
    wt(4);
    chk({pb_oe, pb_o}, 2'h3);
    pwm <= 1'h0;
    wt(4);
    chk({pb_oe, pb_o}, 2'h2);
    lv = pin[7];
    uf1 <= 1'h1;
    wt(1);
    uf1 <= 1'h0;
    wt(6);
    chk(pin[7], !lv);
    key <= 32'h40000080;
    wc(OFS_FUNC, 32'h814);
    wt(8);
    chk({pb_oe, t3c, t1c}, 3'h0);
    key <= 32'h0;
    wt(8);
    chk({pb_oe, t3c, t1c}, 3'h3);
    // Bias pins take over the first three segments.
    wc(OFS_FUNC, 32'h7c0);
    wt(4);
    chk({bias, seg[2:0]}, 6'h38);
    chk(com, 4'hf);
    com_drv <= 4'hd;
    wc(OFS_FUNC, 32'h080);
    wt(4);
    chk(com, 4'h5);
    // Serial pins: receive and clock in, data out on bit five.
    key <= 32'h10;
    wc(OFS_FUNC, 32'h001);
    wt(8);
    chk({srx, sck_in, pin[5]}, 3'h2);
    rc(OFS_BIT_IN, 32'h2cc);
    stx <= 1'h1;
    key <= 32'h0;
    wt(8);
    chk({srx, sck_in, pin[5]}, 3'h7);
    wc(OFS_FUNC, 32'h003);
    wt(8);
    chk({sck_in, pin[6]}, 2'h0);
    // Every internal reset source pulls the reset pin.
    for (int i = 0; i < 3; i++)
    begin
      src <= 3'h1 << i;
      wt(4);
      chk({rs_oe, rs_o, sreq}, 3'h5);
      src <= 3'h0;
      wt(10);
      chk({rs_oe, sreq}, 2'h0);
    end
    bo_en <= 1'h0;
    wt(10);
    chk(bo_run, 1'h0);
    bo_en <= 1'h1;
    wt(10);
    chk(bo_run, 1'h1);
    final_report;
  end
endmodule
